// File: ncs_pkg.sv
// package for the nand copy-back / erase / status host controller
// assumes a 25 MHz system clock and an AHB-Lite register port
package ncs_pkg;
	// nand commands
	localparam logic [7:0] CMD_READ_MAIN   = 8'h00;
	localparam logic [7:0] CMD_COPYBACK    = 8'h8A;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONF  = 8'hD0;
	localparam logic [7:0] CMD_STATUS      = 8'h70;
	localparam logic [7:0] CMD_READ_ID     = 8'h90;
	localparam logic [7:0] CMD_RESET       = 8'hFF;
	localparam logic [7:0] ID_ADDR         = 8'h00;
	// device status register fields
	localparam int          ST_FAIL_BIT    = 0;
	localparam int          ST_READY_BIT   = 6;
	localparam int          ST_WP_BIT      = 7;
	localparam logic [7:0]  ST_RESET_VAL   = 8'hC0;
	// page and plane geometry
	localparam int          PAGE_BYTES     = 528;
	localparam int          PLANE_BIT      = 14;
	localparam int          ERASE_LO_BIT   = 14;
	// timing
	localparam int          CLK_MHZ        = 25;
	localparam int          T_POWERUP_NS   = 1000;
	localparam int          POWERUP_CYC    = (T_POWERUP_NS * CLK_MHZ + 999) / 1000;
	localparam int          STROBE_CYC     = 2;
	localparam int          BUSY_WAIT_CYC  = 4;
	// own register offsets
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_SRC_ADDR   = 8'h04;
	localparam logic [7:0]  REG_DST_ADDR   = 8'h08;
	localparam logic [7:0]  REG_STATUS     = 8'h0C;
	localparam logic [7:0]  REG_RESULT     = 8'h10;
	// operation codes written to ctrl[2:0]
	localparam logic [2:0]  OP_COPYBACK    = 3'h1;
	localparam logic [2:0]  OP_ERASE       = 3'h2;
	localparam logic [2:0]  OP_STATUS      = 3'h3;
	localparam logic [2:0]  OP_READ_ID     = 3'h4;
	localparam logic [2:0]  OP_RESET       = 3'h5;
	// status register bits
	localparam int          SB_BUSY        = 0;
	localparam int          SB_DONE        = 1;
	localparam int          SB_FAIL        = 2;
	localparam int          SB_PLANE_ERR   = 3;
	localparam int          SB_READY_PIN   = 4;
	localparam int          SB_PWR_OK      = 5;
endpackage

// File: ncs_strobe.sv
// one bus cycle on the nand pins: latch (we) or read (re) pulse of fixed width
// assumes start only while idle; pin levels are driven by the parent
`timescale 1ns/100ps
module ncs_strobe
(
	input  wire logic sys_clk,
	input  wire logic srst,
	input  wire logic start,
	output logic      strobe_n,
	output logic      done
);
	logic [3:0] count;
	logic       active;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			active <= 1'b0;
			count  <= 4'h0;
		end
		else if (start && !active)
		begin
			active <= 1'b1;
			count  <= 4'(2 * ncs_pkg::STROBE_CYC);
		end
		else if (active)
		begin
			count <= count - 4'h1;
			if (count == 4'h1)
				active <= 1'b0;
		end
	end

	// low during the first half, high during the second
	assign strobe_n = !(active && count > 4'(ncs_pkg::STROBE_CYC));
	assign done     = active && count == 4'h1;
endmodule // ncs_strobe

// File: ncs_ahb_slave.sv
// ahb-lite slave front end: decodes one word transfer into write/read strobes
// assumes single whole-word transfers; always zero wait states, OKAY response
`timescale 1ns/100ps
module ncs_ahb_slave
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	output logic             wr_en,
	output logic             rd_en,
	output logic [7:0]       reg_addr
);
	logic       wr_pend;
	logic [7:0] addr_q;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wr_pend <= 1'b0;
			addr_q  <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend <= hsel && htrans[1] && hwrite;
			addr_q  <= haddr[7:0];
		end
	end

	assign wr_en    = wr_pend;
	assign rd_en    = hsel && htrans[1] && !hwrite && hready;
	assign reg_addr = wr_pend ? addr_q : haddr[7:0];
endmodule // ncs_ahb_slave

// File: ncs_ctl.sv
// host-side nand controller: copy-back, block erase, status poll, id read, reset
// assumes the nand pins are synchronous to sys_clk; software drives it over ahb-lite
`timescale 1ns/100ps
module ncs_ctl
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// ahb-lite
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic [2:0]  hsize,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// nand pins
	output logic             chip_enable_n,
	output logic             cmd_latch,
	output logic             addr_latch,
	output logic             write_strobe_n,
	output logic             output_strobe_n,
	output logic             write_protect_n,
	input  wire logic [7:0]  io_in,
	output logic [7:0]       io_out,
	output logic             io_oe,
	input  wire logic        ready_busy_n
);
	typedef enum logic [3:0] {
		NCS_PWRUP, NCS_IDLE, NCS_CMD, NCS_ADDR, NCS_WAIT_BUSY, NCS_WAIT_READY,
		NCS_CMD2, NCS_ADDR2, NCS_CONF, NCS_READ, NCS_DONE
	} ncs_state_t;

	ncs_state_t  state;
	logic [2:0]  op;
	logic [24:0] src_addr;
	logic [24:0] dst_addr;
	logic [1:0]  cyc_idx;
	logic [1:0]  read_idx;
	logic [7:0]  dev_status;
	logic [7:0]  id_maker;
	logic [7:0]  id_device;
	logic        done_flag;
	logic        fail_flag;
	logic        plane_err;
	logic        pwr_ok;
	logic        wp_enable;
	logic [7:0]  busy_wait;
	logic [7:0]  pwr_count;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  reg_addr;
	logic        we_start;
	logic        we_done;
	logic        re_start;
	logic        re_done;
	logic        we_n;
	logic        re_n;
	logic [7:0]  next_io;
	logic        latch_cmd;
	logic        latch_addr;
	logic        read_cycle;
	logic        ctrl_wr;
	logic [2:0]  req_op;

	ncs_ahb_slave u_slave
	(
		.sys_clk  (sys_clk),
		.srst     (srst),
		.hsel     (hsel),
		.haddr    (haddr),
		.htrans   (htrans),
		.hwrite   (hwrite),
		.hready   (hready),
		.wr_en    (wr_en),
		.rd_en    (rd_en),
		.reg_addr (reg_addr)
	);

	ncs_strobe u_we
	(
		.sys_clk  (sys_clk),
		.srst     (srst),
		.start    (we_start),
		.strobe_n (we_n),
		.done     (we_done)
	);

	ncs_strobe u_re
	(
		.sys_clk  (sys_clk),
		.srst     (srst),
		.start    (re_start),
		.strobe_n (re_n),
		.done     (re_done)
	);

	assign hreadyout       = 1'b1;
	assign hresp           = 1'b0;
	assign write_strobe_n  = we_n;
	assign output_strobe_n = re_n;
	assign chip_enable_n   = (state == NCS_IDLE) || (state == NCS_PWRUP);
	assign cmd_latch       = latch_cmd;
	assign addr_latch      = latch_addr;
	assign write_protect_n = wp_enable;
	assign io_out          = next_io;
	assign io_oe           = !read_cycle && (latch_cmd || latch_addr);
	assign ctrl_wr         = wr_en && reg_addr == ncs_pkg::REG_CTRL;
	assign req_op          = hwdata[2:0];

	// power-up recovery before the first command
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pwr_count <= 8'h00;
		else if (pwr_count != 8'(ncs_pkg::POWERUP_CYC))
			pwr_count <= pwr_count + 8'h01;
	end
	assign pwr_ok = pwr_count == 8'(ncs_pkg::POWERUP_CYC);

	// register writes
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			src_addr  <= 25'h000_0000;
			dst_addr  <= 25'h000_0000;
			wp_enable <= 1'b0;
		end
		else if (wr_en)
		begin
			if (reg_addr == ncs_pkg::REG_SRC_ADDR)
				src_addr <= hwdata[24:0];
			if (reg_addr == ncs_pkg::REG_DST_ADDR)
				dst_addr <= hwdata[24:0];
			if (reg_addr == ncs_pkg::REG_CTRL)
				wp_enable <= hwdata[8];
		end
	end

	// register reads
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			hrdata <= 32'h0000_0000;
		else if (rd_en)
			unique case (reg_addr)
				ncs_pkg::REG_CTRL:     hrdata <= {23'h00_0000, wp_enable, 5'h00, op};
				ncs_pkg::REG_SRC_ADDR: hrdata <= {7'h00, src_addr};
				ncs_pkg::REG_DST_ADDR: hrdata <= {7'h00, dst_addr};
				ncs_pkg::REG_STATUS:   hrdata <= {26'h000_0000, pwr_ok, ready_busy_n, plane_err,
				                                  fail_flag, done_flag, state != NCS_IDLE};
				ncs_pkg::REG_RESULT:   hrdata <= {8'h00, id_device, id_maker, dev_status};
				default:               hrdata <= 32'h0000_0000;
			endcase
	end

	// byte placed on the bus for the current cycle
	always_comb
	begin
		next_io    = 8'h00;
		latch_cmd  = 1'b0;
		latch_addr = 1'b0;
		read_cycle = 1'b0;
		unique case (state)
			NCS_CMD:
			begin
				latch_cmd = 1'b1;
				unique case (op)
					ncs_pkg::OP_COPYBACK: next_io = ncs_pkg::CMD_READ_MAIN;
					ncs_pkg::OP_ERASE:    next_io = ncs_pkg::CMD_ERASE_SETUP;
					ncs_pkg::OP_STATUS:   next_io = ncs_pkg::CMD_STATUS;
					ncs_pkg::OP_READ_ID:  next_io = ncs_pkg::CMD_READ_ID;
					default:              next_io = ncs_pkg::CMD_RESET;
				endcase
			end
			NCS_ADDR:
			begin
				latch_addr = 1'b1;
				if (op == ncs_pkg::OP_READ_ID)
					next_io = ncs_pkg::ID_ADDR;
				else if (op == ncs_pkg::OP_ERASE)
					next_io = cyc_idx == 2'd0 ? src_addr[16:9] & 8'hE0 : src_addr[24:17];
				else
					unique case (cyc_idx)
						2'd0:    next_io = src_addr[7:0];
						2'd1:    next_io = src_addr[16:9];
						default: next_io = src_addr[24:17];
					endcase
			end
			NCS_CMD2:
			begin
				latch_cmd = 1'b1;
				next_io   = ncs_pkg::CMD_COPYBACK;
			end
			NCS_ADDR2:
			begin
				latch_addr = 1'b1;
				unique case (cyc_idx)
					2'd0:    next_io = dst_addr[7:0];
					2'd1:    next_io = dst_addr[16:9];
					default: next_io = dst_addr[24:17];
				endcase
			end
			NCS_CONF:
			begin
				latch_cmd = 1'b1;
				// confirm only on the first erase pass, status poll after busy
				if (op == ncs_pkg::OP_ERASE && read_idx == 2'd0)
					next_io = ncs_pkg::CMD_ERASE_CONF;
				else
					next_io = ncs_pkg::CMD_STATUS;
			end
			NCS_READ:
				read_cycle = 1'b1;
			default:
				next_io = 8'h00;
		endcase
	end

	assign we_start = (latch_cmd || latch_addr) && !we_done;
	assign re_start = read_cycle && !re_done;

	// sequencer
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state     <= NCS_PWRUP;
			op        <= 3'h0;
			cyc_idx   <= 2'd0;
			read_idx  <= 2'd0;
			busy_wait <= 8'h00;
		end
		else
			unique case (state)
				NCS_PWRUP:
					if (pwr_ok)
						state <= NCS_IDLE;
				NCS_IDLE:
					// codes above reset have no sequence and are refused
					if (ctrl_wr && req_op != 3'h0 && req_op <= ncs_pkg::OP_RESET)
					begin
						op       <= req_op;
						cyc_idx  <= 2'd0;
						read_idx <= 2'd0;
						// same plane only, else refuse
						if (req_op == ncs_pkg::OP_COPYBACK
							&& src_addr[ncs_pkg::PLANE_BIT] != dst_addr[ncs_pkg::PLANE_BIT])
							state <= NCS_IDLE;
						else
							state <= NCS_CMD;
					end
				NCS_CMD:
					if (we_done)
					begin
						if (op == ncs_pkg::OP_STATUS)
							state <= NCS_READ;
						else if (op == ncs_pkg::OP_RESET)
						begin
							busy_wait <= 8'(ncs_pkg::BUSY_WAIT_CYC);
							state     <= NCS_WAIT_BUSY;
						end
						else
							state <= NCS_ADDR;
					end
				NCS_ADDR:
					if (we_done)
					begin
						cyc_idx <= cyc_idx + 2'd1;
						if (op == ncs_pkg::OP_READ_ID)
							state <= NCS_READ;
						else if (op == ncs_pkg::OP_ERASE && cyc_idx == 2'd1)
							state <= NCS_CONF;
						else if (op == ncs_pkg::OP_COPYBACK && cyc_idx == 2'd2)
						begin
							busy_wait <= 8'(ncs_pkg::BUSY_WAIT_CYC);
							state     <= NCS_WAIT_BUSY;
						end
					end
				NCS_WAIT_BUSY:
					if (busy_wait == 8'h00 || !ready_busy_n)
						state <= NCS_WAIT_READY;
					else
						busy_wait <= busy_wait - 8'h01;
				NCS_WAIT_READY:
					if (ready_busy_n)
					begin
						cyc_idx <= 2'd0;
						if (op == ncs_pkg::OP_COPYBACK && read_idx == 2'd0)
						begin
							read_idx <= 2'd1;
							state    <= NCS_CMD2;
						end
						else if (op == ncs_pkg::OP_RESET)
							state <= NCS_DONE;
						else
							state <= NCS_CONF;
					end
				NCS_CMD2:
					if (we_done)
						state <= NCS_ADDR2;
				NCS_ADDR2:
					if (we_done)
					begin
						cyc_idx <= cyc_idx + 2'd1;
						if (cyc_idx == 2'd2)
						begin
							busy_wait <= 8'(ncs_pkg::BUSY_WAIT_CYC);
							read_idx  <= 2'd2;
							state     <= NCS_WAIT_BUSY;
						end
					end
				NCS_CONF:
					if (we_done)
					begin
						if (op == ncs_pkg::OP_ERASE && read_idx == 2'd0)
						begin
							read_idx  <= 2'd2;
							busy_wait <= 8'(ncs_pkg::BUSY_WAIT_CYC);
							state     <= NCS_WAIT_BUSY;
						end
						else
						begin
							read_idx <= 2'd0;
							state    <= NCS_READ;
						end
					end
				NCS_READ:
					if (re_done)
					begin
						read_idx <= read_idx + 2'd1;
						if (op != ncs_pkg::OP_READ_ID || read_idx == 2'd1)
							state <= NCS_DONE;
					end
				NCS_DONE:
					state <= NCS_IDLE;
				default:
					state <= NCS_IDLE;
			endcase
	end

	// results captured from the bus at the end of each read strobe
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			dev_status <= ncs_pkg::ST_RESET_VAL;
			id_maker   <= 8'h00;
			id_device  <= 8'h00;
		end
		else if (state == NCS_READ && re_done)
		begin
			if (op == ncs_pkg::OP_READ_ID)
			begin
				if (read_idx == 2'd0)
					id_maker <= io_in;
				else
					id_device <= io_in;
			end
			else
				dev_status <= io_in;
		end
	end

	// sticky result flags; a new request clears done and fail, and clears plane_err unless it is a cross-plane copy-back
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			done_flag <= 1'b0;
			fail_flag <= 1'b0;
			plane_err <= 1'b0;
		end
		else if (state == NCS_IDLE && ctrl_wr && req_op != 3'h0 && req_op <= ncs_pkg::OP_RESET)
		begin
			done_flag <= 1'b0;
			fail_flag <= 1'b0;
			plane_err <= req_op == ncs_pkg::OP_COPYBACK
				&& src_addr[ncs_pkg::PLANE_BIT] != dst_addr[ncs_pkg::PLANE_BIT];
		end
		else if (state == NCS_DONE)
		begin
			done_flag <= 1'b1;
			if (op == ncs_pkg::OP_COPYBACK || op == ncs_pkg::OP_ERASE)
				fail_flag <= dev_status[ncs_pkg::ST_FAIL_BIT];
		end
	end
endmodule // ncs_ctl

// File: ncs_ctl_props.sv
// checker for ncs_ctl: nand pin sequencing seen at the top ports
// bound to every ncs_ctl; nand pins are synchronous to sys_clk
`timescale 1ns/100ps
module ncs_ctl_props
(
	input wire logic       sys_clk,
	input wire logic       srst,
	input wire logic       chip_enable_n,
	input wire logic       cmd_latch,
	input wire logic       addr_latch,
	input wire logic       write_strobe_n,
	input wire logic       output_strobe_n,
	input wire logic [7:0] io_out,
	input wire logic       io_oe,
	input wire logic       ready_busy_n
);
	localparam int PU = ncs_pkg::POWERUP_CYC;
	logic       we_q;
	logic [7:0] last_cmd;
	logic [1:0] addr_cnt;
	logic [5:0] pwr_cnt;
	wire logic  lat = write_strobe_n && !we_q;
	always_ff @(posedge sys_clk)
		we_q <= srst ? 1'b1 : write_strobe_n;
	always_ff @(posedge sys_clk)
		if (srst)
			pwr_cnt <= 6'h00;
		else if (pwr_cnt != 6'h3F)
			pwr_cnt <= pwr_cnt + 6'h01;
	always_ff @(posedge sys_clk)
		if (srst)
		begin
			last_cmd <= 8'h00;
			addr_cnt <= 2'd0;
		end
		else if (lat && cmd_latch)
		begin
			last_cmd <= io_out;
			addr_cnt <= 2'd0;
		end
		else if (lat && addr_latch)
			addr_cnt <= addr_cnt + 2'd1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	property p_byte;
		$fell(write_strobe_n) |=> (!write_strobe_n && io_oe && $stable(io_out)) ##1 (write_strobe_n && $stable(io_out));
	endproperty
	a_byte: assert property (p_byte) else $error("byte slot malformed");
	property p_pwr;
		!write_strobe_n |-> pwr_cnt >= PU;
	endproperty
	a_pwr: assert property (p_pwr) else $error("strobe before power-up wait");
	property p_ce;
		(!write_strobe_n || !output_strobe_n) |-> !chip_enable_n;
	endproperty
	a_ce: assert property (p_ce) else $error("strobe with chip deselected");
	property p_rd;
		!output_strobe_n |-> !io_oe && (last_cmd == ncs_pkg::CMD_STATUS || last_cmd == ncs_pkg::CMD_READ_ID);
	endproperty
	a_rd: assert property (p_rd) else $error("read cycle outside status or id mode");
	property p_cb;
		lat && cmd_latch && io_out == ncs_pkg::CMD_COPYBACK |-> ready_busy_n && addr_cnt == 2'd3
			&& last_cmd == ncs_pkg::CMD_READ_MAIN;
	endproperty
	a_cb: assert property (p_cb) else $error("copy-back command out of order");
	property p_conf;
		lat && cmd_latch && io_out == ncs_pkg::CMD_ERASE_CONF |-> addr_cnt == 2'd2
			&& last_cmd == ncs_pkg::CMD_ERASE_SETUP;
	endproperty
	a_conf: assert property (p_conf) else $error("erase confirm without two address bytes");
	property p_id;
		lat && addr_latch && last_cmd == ncs_pkg::CMD_READ_ID |-> io_out == ncs_pkg::ID_ADDR;
	endproperty
	a_id: assert property (p_id) else $error("id address not zero");
	property p_ebits;
		lat && addr_latch && last_cmd == ncs_pkg::CMD_ERASE_SETUP && addr_cnt == 2'd0 |-> io_out[4:0] == 5'h00;
	endproperty
	a_ebits: assert property (p_ebits) else $error("erase page bits not zero");
	c_cb: cover property (lat && cmd_latch && io_out == ncs_pkg::CMD_COPYBACK);
	c_conf: cover property (lat && cmd_latch && io_out == ncs_pkg::CMD_ERASE_CONF);
	c_id: cover property (lat && cmd_latch && io_out == ncs_pkg::CMD_READ_ID);
endmodule // ncs_ctl_props

bind ncs_ctl ncs_ctl_props i_ncs_ctl_props (.sys_clk(sys_clk), .srst(srst), .chip_enable_n(chip_enable_n),
	.cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
	.output_strobe_n(output_strobe_n), .io_out(io_out), .io_oe(io_oe), .ready_busy_n(ready_busy_n));

// File: ncs_nand_model.sv
// behavioural nand device for the controller bench
// pins sampled on sys_clk; bytes taken on rising write_strobe_n
`timescale 1ns/100ps
module ncs_nand_model
#(
	parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary
	parameter logic [7:0] DEV_CODE   = 8'h3C, // arbitrary
	parameter int         BUSY_CYC   = 6
)
(
	input wire logic        sys_clk,
	input wire logic        chip_enable_n,
	input wire logic        cmd_latch,
	input wire logic        addr_latch,
	input wire logic        write_strobe_n,
	input wire logic        output_strobe_n,
	input wire logic        write_protect_n,
	input wire logic [7:0]  io_out,
	input wire logic        io_oe,
	input wire logic        fail_inj,
	output logic [7:0]      io_in,
	output logic            ready_busy_n,
	output logic [23:0]     addr_log,
	output logic [7:0]      n_busy
);
	logic       we_q = 1'b1;
	logic       re_q = 1'b1;
	logic       fail = 1'b0;
	logic       idle_rst = 1'b0;
	logic [7:0] cmd = 8'h00;
	logic [1:0] n_addr = 2'd0;
	logic [1:0] id_idx = 2'd0;
	int         busy_cnt = 0;
	logic [7:0] rd;
	logic       drv;
	wire logic  lat = write_strobe_n && !we_q && !chip_enable_n;
	initial addr_log = 24'h00_0000;
	initial n_busy = 8'h00;
	assign ready_busy_n = (busy_cnt == 0);
	assign rd = (cmd == ncs_pkg::CMD_STATUS) ? {write_protect_n, ready_busy_n, 5'h00, fail}
		: (id_idx == 2'd1) ? MAKER_CODE : DEV_CODE;
	assign drv = !chip_enable_n && !io_oe && (cmd == ncs_pkg::CMD_STATUS || cmd == ncs_pkg::CMD_READ_ID);
	assign io_in = drv ? rd : ~rd;
	always @(posedge sys_clk)
	begin
		we_q <= write_strobe_n;
		re_q <= output_strobe_n;
		if (busy_cnt != 0)
			busy_cnt <= busy_cnt - 1;
		if (!output_strobe_n && re_q && id_idx != 2'd3)
			id_idx <= id_idx + 2'd1;
		if (lat && cmd_latch && (ready_busy_n || io_out == ncs_pkg::CMD_STATUS || io_out == ncs_pkg::CMD_RESET))
		begin
			cmd <= io_out;
			n_addr <= 2'd0;
			id_idx <= 2'd0;
			idle_rst <= (io_out == ncs_pkg::CMD_RESET);
			if (io_out == ncs_pkg::CMD_RESET && !idle_rst)
			begin
				busy_cnt <= BUSY_CYC;
				fail <= 1'b0;
				n_busy <= n_busy + 8'h01;
			end
			if (io_out == ncs_pkg::CMD_ERASE_CONF || io_out == ncs_pkg::CMD_COPYBACK)
			begin
				busy_cnt <= BUSY_CYC;
				fail <= fail_inj;
				n_busy <= n_busy + 8'h01;
			end
		end
		if (lat && addr_latch)
		begin
			addr_log <= {addr_log[15:0], io_out};
			n_addr <= n_addr + 2'd1;
			if (cmd == ncs_pkg::CMD_READ_MAIN && n_addr == 2'd2)
			begin
				busy_cnt <= BUSY_CYC;
				n_busy <= n_busy + 8'h01;
			end
		end
	end
endmodule // ncs_nand_model

// File: tb_ncs_ctl.sv
// self-checking bench for ncs_ctl against the nand device model
// one 25 MHz clock; software side reached by an ahb-lite master task
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_ncs_ctl;
	localparam logic [7:0] MAKER = 8'h5A; // arbitrary
	localparam logic [7:0] DEV   = 8'h3C; // arbitrary
	logic        sys_clk, srst, hsel, hwrite, fail_inj, hreadyout, hresp, chip_enable_n, cmd_latch, addr_latch;
	logic        write_strobe_n, output_strobe_n, write_protect_n, io_oe, ready_busy_n;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, st, res;
	logic [7:0]  io_in, io_out, n_busy, nb;
	logic [23:0] addr_log, la;
	int          mismatches = 0;
	int          checks_done = 0;
	ncs_ctl i_ncs_ctl (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hsize(3'b010), .hwrite(hwrite), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n),
		.write_protect_n(write_protect_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
		.ready_busy_n(ready_busy_n));
	ncs_nand_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV)) i_ncs_nand_model (.sys_clk(sys_clk),
		.chip_enable_n(chip_enable_n), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
		.write_strobe_n(write_strobe_n), .output_strobe_n(output_strobe_n), .write_protect_n(write_protect_n),
		.io_out(io_out), .io_oe(io_oe), .fail_inj(fail_inj), .io_in(io_in), .ready_busy_n(ready_busy_n),
		.addr_log(addr_log), .n_busy(n_busy));
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic run_op(input logic [2:0] op, input logic wp);
		int n;
		n = 0;
		ahb(1'b1, ncs_pkg::REG_CTRL, {23'h00_0000, wp, 5'h00, op}, st);
		repeat (4) @(posedge sys_clk);
		do ahb(1'b0, ncs_pkg::REG_STATUS, 32'h0000_0000, st); while (st[ncs_pkg::SB_BUSY] !== 1'b0 && ++n < 500);
		`CHK(st[ncs_pkg::SB_BUSY], 1'b0)
		ahb(1'b0, ncs_pkg::REG_RESULT, 32'h0000_0000, res);
	endtask
	task t_power;
		ahb(1'b1, ncs_pkg::REG_CTRL, 32'h0000_0103, st);
		repeat (4) @(posedge sys_clk);
		ahb(1'b0, ncs_pkg::REG_STATUS, 32'h0000_0000, st);
		`CHK({st[5], st[1]}, 2'b00)
		repeat (30) @(posedge sys_clk);
		ahb(1'b0, ncs_pkg::REG_STATUS, 32'h0000_0000, st);
		`CHK(st[5:4], 2'b11)
		ahb(1'b0, 8'h14, 32'h0000_0000, st);
		`CHK(st, 32'h0000_0000)
	endtask
	task t_status_id;
		for (int w = 0; w < 2; w++)
		begin
			run_op(ncs_pkg::OP_STATUS, w[0]);
			`CHK(res[7:0], {w[0], 7'h40})
		end
		repeat (2)
		begin
			run_op(ncs_pkg::OP_READ_ID, 1'b1);
			`CHK(res[23:8], {DEV, MAKER})
		end
	endtask
	task automatic t_erase(input logic [24:0] a);
		nb = n_busy;
		ahb(1'b1, ncs_pkg::REG_SRC_ADDR, {7'h00, a}, st);
		run_op(ncs_pkg::OP_ERASE, 1'b1);
		`CHK(addr_log[15:0], {a[16:14], 5'h00, a[24:17]})
		`CHK(n_busy, nb + 8'h01)
		`CHK({res[7:0], st[2:1]}, 10'h301)
	endtask
	task automatic t_copy(input logic [24:0] d, input logic f);
		fail_inj <= f;
		nb = n_busy;
		la = addr_log;
		ahb(1'b1, ncs_pkg::REG_SRC_ADDR, 32'h0000_4200, st);
		ahb(1'b1, ncs_pkg::REG_DST_ADDR, {7'h00, d}, st);
		run_op(ncs_pkg::OP_COPYBACK, 1'b1);
		if (d[14])
		begin
			`CHK(addr_log, {d[7:0], d[16:9], d[24:17]})
			`CHK(n_busy, nb + 8'h02)
			`CHK({res[0], st[2]}, {f, f})
		end
		else
		begin
			`CHK({st[3:1], n_busy, addr_log}, {3'b100, nb, la})
		end
	endtask
	task t_reset;
		nb = n_busy;
		run_op(ncs_pkg::OP_RESET, 1'b1);
		`CHK(n_busy, nb + 8'h01)
		run_op(ncs_pkg::OP_RESET, 1'b1);
		`CHK({n_busy, st[1]}, {nb + 8'h01, 1'b1})
		run_op(ncs_pkg::OP_STATUS, 1'b1);
		`CHK(res[7:0], ncs_pkg::ST_RESET_VAL)
	endtask
	task close_out;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		close_out();
	end
	initial
	begin
		srst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		fail_inj = 1'b0;
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		t_power();
		t_status_id();
		t_erase(25'h1AB_CDEF);
		t_copy(25'h100_4600, 1'b0);
		t_copy(25'h100_4600, 1'b1);
		t_copy(25'h100_0600, 1'b0);
		t_reset();
		close_out();
	end
endmodule // tb_ncs_ctl
